// ===== logic/pwsd_defines.vh
// How it works
// - shutdown status flag, bit 7, set on a shutdown event; outputs then in safe state
// - bits 6..4 select shutdown sources: comparators, low level on interrupt pin, or combinations
// - bits 3..2 give pair a/c safe state: low, high or high impedance
// - bits 1..0 give pair b/d safe state: low, high or high impedance
// - comparator two sync option delays comparator two through the timer one tick
// - shutdown is level based and persists while the selected source stays present
// - software writes to the status flag are ignored while the condition persists
// - after restart the waveform resumes only at the next period start
// - with auto restart the flag stays set during condition, then clears itself
// - half-bridge dead-band delays only inactive-to-active edges
// - seven-bit dead-band count gives the delay in instruction cycles
// - bit 7 enables auto restart; forced to zero by two-speed or fail-safe clocking
// - single output mode steers the waveform to any one to four pins
// - steering bits 3..0 for d,c,b,a put the waveform on a pin, else port data
// - mode field low two bits set polarity of steered pins
// - steering sync bit 4: update at next period, else at once
// - in steering mode shutdown touches only steered pins
// - steering only when mode bits are 11 and output config is 00
// - a shutdown event forces the pins without waiting for a period boundary
// - software setting the status flag is a shutdown event
// - dead-band longer than duty keeps the delayed output inactive all cycle
`ifndef PWSD_DEFINES_VH
`define PWSD_DEFINES_VH
`define PWSD_ADDR_SHUT 5'h00
`define PWSD_ADDR_DBND 5'h04
`define PWSD_ADDR_STEER 5'h08
`define PWSD_ADDR_CCP 5'h0c
`define PWSD_ADDR_STAT 5'h10
`define PWSD_SHUT_RST 8'h00
`define PWSD_FLAG_RST 1'b0
`define PWSD_STEER_EFF_RST 4'h1
`define PWSD_DBND_RST 8'h00
`define PWSD_STEER_RST 5'h01
`define PWSD_CCP_RST 6'h00
`define PWSD_FLAG_BIT 7
`define PWSD_SRC_HI 6
`define PWSD_SRC_LO 4
`define PWSD_AC_HI 3
`define PWSD_AC_LO 2
`define PWSD_BD_HI 1
`define PWSD_BD_LO 0
`define PWSD_RESTART_BIT 7
`define PWSD_DB_HI 6
`define PWSD_SYNC_BIT 4
`define PWSD_CFG_HI 7
`define PWSD_CFG_LO 6
`define PWSD_MODE_HI 3
`define PWSD_MODE_LO 0
`define PWSD_MODE_PWM 2'h3
`define PWSD_CFG_SINGLE 2'h0
`define PWSD_CFG_HALF 2'h2
`define PWSD_SS_LOW 2'h0
`define PWSD_SS_HIGH 2'h1
`define PWSD_RESP_OK 2'h0
`define PWSD_RESP_SLVERR 2'h2
`define PWSD_DB_MAX 7'h7f
`endif

// ===== logic/pwsd_top.v
`timescale 1ns/1ns
`include "pwsd_defines.vh"
module pwsd_top (
	input wire CORE_CLK_I,
	input wire ARST_N_I,
	input wire CLK_EN_I,
	input wire [4:0] S_AXI_AWADDR_I,
	input wire S_AXI_AWVALID_I,
	output reg S_AXI_AWREADY_O,
	input wire [31:0] S_AXI_WDATA_I,
	input wire [3:0] S_AXI_WSTRB_I,
	input wire S_AXI_WVALID_I,
	output reg S_AXI_WREADY_O,
	output reg [1:0] S_AXI_BRESP_O,
	output reg S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire [4:0] S_AXI_ARADDR_I,
	input wire S_AXI_ARVALID_I,
	output reg S_AXI_ARREADY_O,
	output reg [31:0] S_AXI_RDATA_O,
	output reg [1:0] S_AXI_RRESP_O,
	output reg S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I,
	input wire PWM_RAW_I,
	input wire PERIOD_START_I,
	input wire TIMER1_TICK_I,
	input wire CLK_MON_FORCE_I,
	input wire [3:0] PORT_DATA_I,
	input wire [3:0] PORT_OE_I,
	input wire COMP1_I,
	input wire COMP2_I,
	input wire INT_PIN_N_I,
	output reg [3:0] PIN_O,
	output reg [3:0] PIN_OE_O
);

	// register state
	reg flag_ff;
	reg [2:0] src_sel_ff;
	reg [1:0] ss_ac_ff;
	reg [1:0] ss_bd_ff;
	reg restart_en_ff;
	reg [6:0] deadband_ff;
	reg [4:0] steer_ff;
	reg [3:0] steer_eff_ff;
	reg [1:0] cfg_ff;
	reg [3:0] mode_ff;
	reg c2_sync_ff;
	reg running_ff;

	// pin synchronisers
	reg [2:0] sync1_ff;
	reg [2:0] sync2_ff;
	reg c2_held_ff;

	// bus state
	reg aw_got_ff;
	reg w_got_ff;
	reg [4:0] awaddr_ff;
	reg [7:0] wdata_ff;
	reg wstrb0_ff;

	always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
		end else if (CLK_EN_I) begin
			sync1_ff <= {~INT_PIN_N_I, COMP2_I, COMP1_I};
			sync2_ff <= sync1_ff;
		end
	end

	wire c1_lvl = sync2_ff[0];
	wire c2_raw = sync2_ff[1];
	wire int_low = sync2_ff[2];

	// comparator two optionally resampled on the timer one tick
	always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			c2_held_ff <= 1'b0;
		end else if (CLK_EN_I && TIMER1_TICK_I) begin
			c2_held_ff <= c2_raw;
		end
	end

	wire c2_lvl = c2_sync_ff ? c2_held_ff : c2_raw;

	reg cond;
	always @* begin
		case (src_sel_ff)
		3'h0: cond = 1'b0;
		3'h1: cond = c1_lvl;
		3'h2: cond = c2_lvl;
		3'h3: cond = c1_lvl | c2_lvl;
		3'h4: cond = int_low;
		3'h5: cond = int_low | c1_lvl;
		3'h6: cond = int_low | c2_lvl;
		3'h7: cond = int_low | c1_lvl | c2_lvl;
		default: cond = 1'b0;
		endcase
	end

	// bus write channel
	wire aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
	wire w_take = S_AXI_WVALID_I & S_AXI_WREADY_O;
	wire wr_fire = aw_got_ff & w_got_ff & ~S_AXI_BVALID_O;
	wire wr_en = wr_fire & wstrb0_ff;
	wire wr_shut = wr_en && (awaddr_ff == `PWSD_ADDR_SHUT);
	wire wr_dbnd = wr_en && (awaddr_ff == `PWSD_ADDR_DBND);
	wire wr_steer = wr_en && (awaddr_ff == `PWSD_ADDR_STEER);
	wire wr_ccp = wr_en && (awaddr_ff == `PWSD_ADDR_CCP);
	wire wr_map = (awaddr_ff == `PWSD_ADDR_SHUT) || (awaddr_ff == `PWSD_ADDR_DBND) ||
		(awaddr_ff == `PWSD_ADDR_STEER) || (awaddr_ff == `PWSD_ADDR_CCP) ||
		(awaddr_ff == `PWSD_ADDR_STAT);

	always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 5'h00;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O <= 1'b0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= `PWSD_RESP_OK;
		end else if (CLK_EN_I) begin
			S_AXI_AWREADY_O <= ~aw_got_ff & ~aw_take;
			S_AXI_WREADY_O <= ~w_got_ff & ~w_take;
			if (aw_take) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= {S_AXI_AWADDR_I[4:2], 2'h0};
			end
			if (w_take) begin
				w_got_ff <= 1'b1;
				wdata_ff <= S_AXI_WDATA_I[7:0];
				wstrb0_ff <= S_AXI_WSTRB_I[0];
			end
			if (wr_fire) begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= wr_map ? `PWSD_RESP_OK : `PWSD_RESP_SLVERR;
			end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				S_AXI_AWREADY_O <= 1'b1;
				S_AXI_WREADY_O <= 1'b1;
			end
		end
	end

	// control registers
	reg nxt_flag;
	always @* begin
		nxt_flag = flag_ff;
		if (cond) begin
			nxt_flag = 1'b1;
		end else if (wr_shut && wdata_ff[`PWSD_FLAG_BIT]) begin
			nxt_flag = 1'b1;
		end else if (restart_en_ff && flag_ff) begin
			nxt_flag = 1'b0;
		end else if (wr_shut) begin
			nxt_flag = 1'b0;
		end
	end

	always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			flag_ff <= `PWSD_FLAG_RST;
			src_sel_ff <= 3'h0;
			ss_ac_ff <= 2'h0;
			ss_bd_ff <= 2'h0;
			restart_en_ff <= 1'b0;
			deadband_ff <= 7'h00;
			steer_ff <= `PWSD_STEER_RST;
			cfg_ff <= 2'h0;
			mode_ff <= 4'h0;
			c2_sync_ff <= 1'b0;
		end else if (CLK_EN_I) begin
			flag_ff <= nxt_flag;
			if (wr_shut) begin
				src_sel_ff <= wdata_ff[`PWSD_SRC_HI:`PWSD_SRC_LO];
				ss_ac_ff <= wdata_ff[`PWSD_AC_HI:`PWSD_AC_LO];
				ss_bd_ff <= wdata_ff[`PWSD_BD_HI:`PWSD_BD_LO];
			end
			if (wr_dbnd) begin
				deadband_ff <= wdata_ff[`PWSD_DB_HI:0];
			end
			if (CLK_MON_FORCE_I) begin
				restart_en_ff <= 1'b0;
			end else if (wr_dbnd) begin
				restart_en_ff <= wdata_ff[`PWSD_RESTART_BIT];
			end
			if (wr_steer) begin
				steer_ff <= wdata_ff[4:0];
			end
			if (wr_ccp) begin
				cfg_ff <= wdata_ff[`PWSD_CFG_HI:`PWSD_CFG_LO];
				mode_ff <= wdata_ff[`PWSD_MODE_HI:`PWSD_MODE_LO];
				c2_sync_ff <= wdata_ff[5];
			end
		end
	end

	// restart and steering update timing
	always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			running_ff <= 1'b1;
			steer_eff_ff <= `PWSD_STEER_EFF_RST;
		end else if (CLK_EN_I) begin
			if (nxt_flag) begin
				running_ff <= 1'b0;
			end else if (PERIOD_START_I) begin
				running_ff <= 1'b1;
			end
			if (!steer_ff[`PWSD_SYNC_BIT] || PERIOD_START_I) begin
				steer_eff_ff <= steer_ff[3:0];
			end
		end
	end

	wire pwm_mode = (mode_ff[3:2] == `PWSD_MODE_PWM);
	wire steer_mode = pwm_mode && (cfg_ff == `PWSD_CFG_SINGLE);
	wire half_mode = pwm_mode && (cfg_ff == `PWSD_CFG_HALF);
	wire shut_now = flag_ff | cond | ~running_ff;

	// dead-band counters for the half-bridge pair
	reg [6:0] db_cnt_ff [0:1];
	wire [1:0] hb_raw = {~PWM_RAW_I, PWM_RAW_I};
	wire [1:0] hb_del;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_db
			always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					db_cnt_ff[g] <= 7'h00;
				end else if (CLK_EN_I) begin
					if (!hb_raw[g]) begin
						db_cnt_ff[g] <= 7'h00;
					end else if (db_cnt_ff[g] != `PWSD_DB_MAX) begin
						db_cnt_ff[g] <= db_cnt_ff[g] + 7'h01;
					end
				end
			end
			assign hb_del[g] = hb_raw[g] && (db_cnt_ff[g] >= deadband_ff);
		end
	endgenerate

	// pin drivers
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_pin
			reg owned;
			reg wave;
			reg [1:0] ss;
			always @* begin
				ss = (g % 2 == 0) ? ss_ac_ff : ss_bd_ff;
				if (steer_mode) begin
					owned = steer_eff_ff[g];
					wave = PWM_RAW_I;
				end else if (half_mode) begin
					owned = (g < 2);
					wave = (g < 2) ? hb_del[g % 2] : 1'b0;
				end else begin
					owned = pwm_mode && (g == 0);
					wave = PWM_RAW_I;
				end
				wave = wave ^ ((g % 2 == 0) ? mode_ff[1] : mode_ff[0]);
			end
			always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					PIN_O[g] <= 1'b0;
					PIN_OE_O[g] <= 1'b0;
				end else if (CLK_EN_I) begin
					if (!owned) begin
						PIN_O[g] <= PORT_DATA_I[g];
						PIN_OE_O[g] <= PORT_OE_I[g];
					end else if (shut_now) begin
						PIN_O[g] <= (ss == `PWSD_SS_HIGH);
						PIN_OE_O[g] <= ~ss[1];
					end else begin
						PIN_O[g] <= wave;
						PIN_OE_O[g] <= PORT_OE_I[g];
					end
				end
			end
		end
	endgenerate

	// bus read channel
	reg [7:0] rd_val;
	reg rd_ok;
	always @* begin
		rd_ok = 1'b1;
		case ({S_AXI_ARADDR_I[4:2], 2'h0})
		`PWSD_ADDR_SHUT: rd_val = {flag_ff, src_sel_ff, ss_ac_ff, ss_bd_ff};
		`PWSD_ADDR_DBND: rd_val = {restart_en_ff, deadband_ff};
		`PWSD_ADDR_STEER: rd_val = {3'h0, steer_ff};
		`PWSD_ADDR_CCP: rd_val = {cfg_ff, c2_sync_ff, 1'b0, mode_ff};
		`PWSD_ADDR_STAT: rd_val = {steer_eff_ff, 1'b0, steer_mode, running_ff, cond};
		default: begin
			rd_val = 8'h00;
			rd_ok = 1'b0;
		end
		endcase
	end

	always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h0000_0000;
			S_AXI_RRESP_O <= `PWSD_RESP_OK;
		end else if (CLK_EN_I) begin
			if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
				S_AXI_ARREADY_O <= 1'b0;
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O <= {24'h00_0000, rd_val};
				S_AXI_RRESP_O <= rd_ok ? `PWSD_RESP_OK : `PWSD_RESP_SLVERR;
			end else if (S_AXI_RVALID_O) begin
				if (S_AXI_RREADY_I) begin
					S_AXI_RVALID_O <= 1'b0;
					S_AXI_ARREADY_O <= 1'b1;
				end
			end else begin
				S_AXI_ARREADY_O <= 1'b1;
			end
		end
	end

endmodule // pwsd_top

// ===== test/pwsd_top_asserts.sv
`timescale 1ns/1ns
module pwsd_top_asserts (
	input wire CORE_CLK_I,
	input wire ARST_N_I,
	input wire CLK_EN_I,
	input wire S_AXI_AWVALID_I,
	input wire S_AXI_AWREADY_O,
	input wire S_AXI_WVALID_I,
	input wire S_AXI_WREADY_O,
	input wire S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire [1:0] S_AXI_BRESP_O,
	input wire S_AXI_ARVALID_I,
	input wire S_AXI_ARREADY_O,
	input wire S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I,
	input wire [31:0] S_AXI_RDATA_O
);
	default clocking dc @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!ARST_N_I);
	sequence s_wr_take;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O && CLK_EN_I;
	endsequence
	sequence s_rd_take;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O && CLK_EN_I;
	endsequence
	a_write_answer: assert property (s_wr_take |=> ##1 S_AXI_BVALID_O)
		else $error("write not answered");
	a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID_O)
		else $error("read not answered");
	a_read_busy: assert property (s_rd_take |=> !S_AXI_ARREADY_O [*1] ##0 S_AXI_RVALID_O)
		else $error("read address ready while busy");
	a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response dropped");
	a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data dropped");
	a_rdata_byte: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_bresp_code: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O[0] == 1'b0)
		else $error("bad write response code");
	a_b_release: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I && CLK_EN_I |=> !S_AXI_BVALID_O)
		else $error("write response held too long");
endmodule // pwsd_top_asserts
bind pwsd_top pwsd_top_asserts u_asserts (.*);

// ===== test/pwsd_far_model.sv
`timescale 1ns/1ns
module pwsd_far_model (
	input wire logic clk_i,
	input wire logic [2:0] trip_i,
	output logic comp1_o = 1'b0,
	output logic comp2_o = 1'b0,
	output logic int_n_o = 1'b1
);
	always @(posedge clk_i) begin
		comp1_o <= trip_i[0];
		comp2_o <= trip_i[1];
		int_n_o <= !trip_i[2];
	end
endmodule // pwsd_far_model

// ===== test/pwsd_top_tb.sv
`timescale 1ns/1ns
module pwsd_top_tb;
	logic CORE_CLK_I = 1'b0, ARST_N_I = 1'b0, CLK_EN_I = 1'b1, S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
	logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0, PWM_RAW_I = 1'b1;
	logic PERIOD_START_I = 1'b0, TIMER1_TICK_I = 1'b0, CLK_MON_FORCE_I = 1'b0;
	logic [4:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
	logic [31:0] S_AXI_WDATA_I = '0;
	logic [3:0] S_AXI_WSTRB_I = '0, PORT_DATA_I = '0, PORT_OE_I = 4'hf;
	logic [2:0] trip = '0;
	logic [7:0] seed;
	wire S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
	wire COMP1_I, COMP2_I, INT_PIN_N_I;
	wire [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
	wire [31:0] S_AXI_RDATA_O;
	wire [3:0] PIN_O, PIN_OE_O;
	logic [33:0] q[$];
	int errors = 0, checked = 0, cyc = 0;
	pwsd_top u_dut (.*);
	pwsd_far_model u_far (.clk_i(CORE_CLK_I), .trip_i(trip), .comp1_o(COMP1_I), .comp2_o(COMP2_I), .int_n_o(INT_PIN_N_I));
	initial begin
		forever #5 CORE_CLK_I = !CORE_CLK_I;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic test_done;
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge CORE_CLK_I);
	endtask
	task automatic pc(input logic [7:0] e);
		#1;
		chk({26'h000_0000, PIN_OE_O, PIN_O}, {26'h000_0000, e});
	endtask
	task automatic ps;
		@(posedge CORE_CLK_I);
		PERIOD_START_I <= 1'b1;
		@(posedge CORE_CLK_I);
		PERIOD_START_I <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge CORE_CLK_I);
		S_AXI_AWADDR_I <= a;
		S_AXI_WDATA_I <= {24'h00_0000, d};
		S_AXI_WSTRB_I <= 4'h1;
		S_AXI_AWVALID_I <= 1'b1;
		S_AXI_WVALID_I <= 1'b1;
		S_AXI_BREADY_I <= 1'b1;
		do begin
			@(posedge CORE_CLK_I);
			if (S_AXI_AWREADY_O)
				S_AXI_AWVALID_I <= 1'b0;
			if (S_AXI_WREADY_O)
				S_AXI_WVALID_I <= 1'b0;
		end while (!S_AXI_BVALID_O);
		S_AXI_BREADY_I <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [1:0] r, input logic [7:0] d);
		@(posedge CORE_CLK_I);
		q.push_back({r, 24'h00_0000, d});
		S_AXI_ARADDR_I <= a;
		S_AXI_ARVALID_I <= 1'b1;
		S_AXI_RREADY_I <= 1'b1;
		do begin
			@(posedge CORE_CLK_I);
			if (S_AXI_ARREADY_O)
				S_AXI_ARVALID_I <= 1'b0;
		end while (!S_AXI_RVALID_O);
		S_AXI_RREADY_I <= 1'b0;
	endtask
	always @(posedge CORE_CLK_I) begin
		if (S_AXI_RVALID_O && S_AXI_RREADY_I)
			chk({S_AXI_RRESP_O, S_AXI_RDATA_O}, q.pop_front());
		cyc++;
		if (cyc == 4000) begin
			errors++;
			test_done;
		end
	end
	initial begin
		seed = lfsr(8'h19);
		PORT_DATA_I <= seed[3:0];
		w(3);
		ARST_N_I <= 1'b1;
		w(2);
		rd(5'h00, 2'h0, 8'h00);
		rd(5'h08, 2'h0, 8'h01);
		rd(5'h14, 2'h2, 8'h00);
		wr(5'h08, 8'hff);
		rd(5'h08, 2'h0, 8'h1f);
		wr(5'h08, 8'h05);
		wr(5'h0c, 8'h0c);
		wr(5'h00, 8'h42);
		ps;
		w(3);
		pc({4'hf, PORT_DATA_I[3], 1'b1, PORT_DATA_I[1], 1'b1});
		trip <= 3'h4;
		w(6);
		pc({4'hf, PORT_DATA_I[3], 1'b0, PORT_DATA_I[1], 1'b0});
		rd(5'h00, 2'h0, 8'hc2);
		wr(5'h00, 8'h42);
		rd(5'h00, 2'h0, 8'hc2);
		trip <= 3'h0;
		w(6);
		rd(5'h00, 2'h0, 8'hc2);
		wr(5'h00, 8'h42);
		rd(5'h00, 2'h0, 8'h42);
		pc({4'hf, PORT_DATA_I[3], 1'b0, PORT_DATA_I[1], 1'b0});
		ps;
		w(3);
		pc({4'hf, PORT_DATA_I[3], 1'b1, PORT_DATA_I[1], 1'b1});
		wr(5'h08, 8'h0f);
		trip <= 3'h4;
		w(6);
		#1;
		chk({30'h0000_0000, PIN_OE_O}, 34'h0_0000_0005);
		wr(5'h04, 8'h80);
		trip <= 3'h0;
		w(6);
		rd(5'h00, 2'h0, 8'h42);
		CLK_MON_FORCE_I <= 1'b1;
		w(3);
		rd(5'h04, 2'h0, 8'h00);
		wr(5'h00, 8'hc2);
		rd(5'h00, 2'h0, 8'hc2);
		wr(5'h00, 8'h42);
		wr(5'h0c, 8'h0e);
		ps;
		w(3);
		pc(8'hfa);
		wr(5'h08, 8'h11);
		w(3);
		pc(8'hfa);
		ps;
		w(3);
		pc({4'hf, PORT_DATA_I[3:1], 1'b0});
		wr(5'h0c, 8'h8c);
		wr(5'h04, 8'h03);
		PWM_RAW_I <= 1'b0;
		w(3);
		pc({4'hf, PORT_DATA_I[3:2], 2'b00});
		w(1);
		pc({4'hf, PORT_DATA_I[3:2], 2'b10});
		w(1);
		PWM_RAW_I <= 1'b1;
		w(2);
		pc({4'hf, PORT_DATA_I[3:2], 2'b00});
		w(1);
		PWM_RAW_I <= 1'b0;
		w(2);
		pc({4'hf, PORT_DATA_I[3:2], 2'b00});
		test_done;
	end
endmodule // pwsd_top_tb
